// ### design/mrf_formatter.sv
// mrf_formatter: turns queued measurement results into response byte
// streams, decimal text or a definite-length block of binary doubles.
// assumes value inputs and the format setting come from logic on clk_i.
//
// Contract
// - text mode prints each value as integer, fixed-point or exponent form
// - consecutive text values are separated by a comma
// - a binary block starts with the number-sign byte
// - then one digit counting length digits, then decimal payload length
// - every response ends with newline flagged as end of message
// - each binary value is an eight-byte double
// - binary values go out most significant byte first
// - normal doubles pass unchanged, implied leading one kept
// - zero-exponent doubles pass unchanged, subnormals and zero intact
`timescale 1ns/1ns
`default_nettype none

module mrf_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    // fill side
    input  wire logic         wr_valid_i,
    output logic              wr_ready_o,
    input  wire logic [W-1:0] wr_data_i,
    // drain side
    output logic              rd_valid_o,
    input  wire logic         rd_ready_i,
    output logic      [W-1:0] rd_data_o
);
    // depth must be a power of two, pointers wrap by overflow
    localparam int AW = $clog2(D);
    logic [W-1:0] mem_q [D];
    logic [W-1:0] mem_d [D];
    logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [AW:0]   cnt_q, cnt_d;
    logic          wr, rd;

    assign wr_ready_o = cnt_q != (AW+1)'(D);
    assign rd_valid_o = cnt_q != '0;
    assign rd_data_o  = mem_q[rp_q];
    assign wr         = wr_valid_i && wr_ready_o;
    assign rd         = rd_valid_o && rd_ready_i;

    for (genvar g = 0; g < D; g++) begin : g_ent
        assign mem_d[g] = (wr && wp_q == AW'(g)) ? wr_data_i : mem_q[g];
    end

    always_comb begin
        wp_d  = wr ? wp_q + 1'b1 : wp_q;
        rp_d  = rd ? rp_q + 1'b1 : rp_q;
        cnt_d = cnt_q + {{AW{1'b0}}, wr} - {{AW{1'b0}}, rd};
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
            for (int i = 0; i < D; i++) mem_q[i] <= '0;
        end else begin
            wp_q  <= wp_d;
            rp_q  <= rp_d;
            cnt_q <= cnt_d;
            for (int i = 0; i < D; i++) mem_q[i] <= mem_d[i];
        end
    end
endmodule : mrf_fifo

module mrf_formatter
    import mrf_pkg::*;
#(
    parameter int DEPTH = FIFO_D
) (
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    // format setting, 1 = binary block
    input  wire logic              fmt_binary_i,
    // measurement values
    input  wire logic              val_valid_i,
    output logic                   val_ready_o,
    input  wire logic [VAL_W-1:0]  val_bits_i,
    input  wire logic [MANT_W-1:0] val_mant_i,
    input  wire logic [EXP_W-1:0]  val_dexp_i,
    input  wire logic [CNT_W-1:0]  val_count_i,
    // response bytes to the bus controller
    output logic                   byte_valid_o,
    input  wire logic              byte_ready_i,
    output logic [BYTE_W-1:0]      byte_data_o,
    output logic                   byte_end_o
);
    // -----------------------------------------------------------------
    // helpers
    // -----------------------------------------------------------------
    function automatic logic [3:0] dig_at(input logic [31:0] v, input logic [3:0] i);
        logic [31:0] t;
        t = v;
        for (int k = 0; k < NDIG_MAX; k++) if (4'(k) < i) t = t / 32'd10;
        return 4'(t % 32'd10);
    endfunction : dig_at

    function automatic logic [3:0] num_dig(input logic [31:0] v);
        logic [31:0] t;
        logic [3:0]  n;
        n = 4'h1;
        t = v / 32'd10;
        for (int k = 1; k < NDIG_MAX; k++) begin
            if (t != '0) begin
                n = n + 4'h1;
                t = t / 32'd10;
            end
        end
        return n;
    endfunction : num_dig

    // -----------------------------------------------------------------
    // value queue
    // -----------------------------------------------------------------
    logic              f_valid, f_pop;
    logic [FIFO_W-1:0] f_data;
    logic [VAL_W-1:0]  h_bits;
    logic [MANT_W-1:0] h_mant;
    logic signed [EXP_W-1:0] h_dexp;
    logic [CNT_W-1:0]  h_cnt;
    logic [7:0]        h_top;

    mrf_fifo #(.W(FIFO_W), .D(DEPTH)) u_fifo (
        .clk_i      (clk_i),
        .rst_n_i    (rst_n_i),
        .wr_valid_i (val_valid_i),
        .wr_ready_o (val_ready_o),
        .wr_data_i  ({val_count_i, val_dexp_i, val_mant_i, val_bits_i}),
        .rd_valid_o (f_valid),
        .rd_ready_i (f_pop),
        .rd_data_o  (f_data)
    );

    assign h_bits = f_data[BITS_LSB +: VAL_W];
    assign h_mant = f_data[MANT_LSB +: MANT_W];
    assign h_dexp = $signed(f_data[DEXP_LSB +: EXP_W]);
    assign h_cnt  = f_data[CNT_LSB +: CNT_W];
    assign h_top  = h_bits[VAL_W-1 -: 8];

    // -----------------------------------------------------------------
    // response sequencer
    // -----------------------------------------------------------------
    mrf_state_e st_q, st_d;
    logic             fmt_bin_q, fmt_bin_d;
    logic [CNT_W-1:0] left_q, left_d;
    logic [LEN_W-1:0] len_q, len_d;
    logic [2:0]       bix_q, bix_d;
    logic [3:0]       idx_q, idx_d, nd_q, nd_d, pt_at_q, pt_at_d;
    logic [31:0]      mag_q, mag_d;
    logic             neg_q, neg_d, nr3_q, nr3_d, pt_q, pt_d;
    logic             eneg_q, eneg_d;
    logic [6:0]       emag_q, emag_d;
    logic             bv_q, bv_d, be_q, be_d;
    logic [7:0]       bd_q, bd_d;
    logic             emit_c;
    logic [CNT_W-1:0] cnt_eff;
    logic [7:0]       nfrac;
    logic [9:0]       eexp, eabs;
    logic [3:0]       ndv;

    assign byte_valid_o = bv_q;
    assign byte_data_o  = bd_q;
    assign byte_end_o   = be_q;
    // a held byte leaves only when taken, so new bytes wait on ready
    assign emit_c = !bv_q || byte_ready_i;

    always_comb begin
        st_d = st_q;
        fmt_bin_d = fmt_bin_q;
        left_d = left_q;
        len_d = len_q;
        bix_d = bix_q;
        idx_d = idx_q;
        nd_d = nd_q;
        pt_at_d = pt_at_q;
        mag_d = mag_q;
        neg_d = neg_q;
        nr3_d = nr3_q;
        pt_d = pt_q;
        eneg_d = eneg_q;
        emag_d = emag_q;
        bv_d = bv_q && !byte_ready_i;
        bd_d = bd_q;
        be_d = be_q && !byte_ready_i;
        f_pop = 1'b0;
        cnt_eff = (h_cnt == '0) ? CNT_W'(1) : h_cnt;
        ndv = num_dig(mag_q);
        nfrac = 8'(-h_dexp);
        eexp = '0;
        eabs = '0;
        case (st_q)
            S_IDLE: if (f_valid) begin
                fmt_bin_d = fmt_binary_i;
                left_d = cnt_eff;
                len_d = LEN_W'({cnt_eff, 3'h0});
                st_d = fmt_binary_i ? S_HASH : S_TLOAD;
            end
            S_HASH: if (emit_c) begin
                bv_d = 1'b1;
                bd_d = CH_HASH;
                st_d = S_NDIG;
            end
            S_NDIG: if (emit_c) begin
                bv_d = 1'b1;
                bd_d = CH_0 + {4'h0, num_dig(32'(len_q))};
                idx_d = num_dig(32'(len_q)) - 4'h1;
                st_d = S_LEN;
            end
            S_LEN: if (emit_c) begin
                bv_d = 1'b1;
                bd_d = CH_0 + {4'h0, dig_at(32'(len_q), idx_q)};
                idx_d = idx_q - 4'h1;
                bix_d = LAST_BYTE_IX;
                if (idx_q == '0) st_d = S_BIN;
            end
            S_BIN: if (emit_c && f_valid) begin
                // doubles pass bit for bit, so normal and zero-exponent
                // encodings both survive unchanged
                bv_d = 1'b1;
                bd_d = h_bits[{bix_q, 3'h0} +: 8];
                bix_d = bix_q - 3'h1;
                if (bix_q == '0) begin
                    f_pop = 1'b1;
                    left_d = left_q - CNT_W'(1);
                    if (left_q == CNT_W'(1)) st_d = S_TERM;
                end
            end
            S_TLOAD: if (f_valid) begin
                neg_d = h_mant[MANT_W-1];
                mag_d = h_mant[MANT_W-1] ? 32'(-h_mant) : h_mant;
                st_d = S_TSIGN;
            end
            S_TSIGN: if (emit_c) begin
                // form choice: NR1 for dexp 0, NR2 if an integer digit
                // remains, NR3 otherwise
                bv_d = 1'b1;
                bd_d = neg_q ? CH_MINUS : CH_PLUS;
                nd_d = ndv;
                idx_d = ndv - 4'h1;
                pt_d = 1'b0;
                nr3_d = 1'b0;
                pt_at_d = ndv - 4'h1;
                if (h_dexp < 0 && nfrac < {4'h0, ndv}) begin
                    pt_d = 1'b1;
                    pt_at_d = nfrac[3:0];
                end else if (h_dexp != 0) begin
                    pt_d = 1'b1;
                    nr3_d = 1'b1;
                end
                eexp = {{2{h_dexp[EXP_W-1]}}, h_dexp} + {6'h0, ndv} - 10'h1;
                eabs = eexp[9] ? 10'(-eexp) : eexp;
                eneg_d = eexp[9];
                // two exponent digits only, large exponents saturate
                emag_d = (eabs > {3'h0, EXP_CLAMP}) ? EXP_CLAMP : eabs[6:0];
                st_d = S_TDIG;
            end
            S_TDIG: if (emit_c) begin
                bv_d = 1'b1;
                bd_d = CH_0 + {4'h0, dig_at(mag_q, idx_q)};
                if (pt_q && idx_q == pt_at_q) st_d = S_TPT;
                else if (idx_q == '0) st_d = nr3_q ? S_TE : S_COMMA;
                else idx_d = idx_q - 4'h1;
            end
            S_TPT: if (emit_c) begin
                bv_d = 1'b1;
                bd_d = CH_DOT;
                if (idx_q == '0) st_d = S_TZ;
                else begin
                    idx_d = idx_q - 4'h1;
                    st_d = S_TDIG;
                end
            end
            S_TZ: if (emit_c) begin
                bv_d = 1'b1;
                bd_d = CH_0;
                st_d = S_TE;
            end
            S_TE: if (emit_c) begin
                bv_d = 1'b1;
                bd_d = CH_E;
                st_d = S_TES;
            end
            S_TES: if (emit_c) begin
                bv_d = 1'b1;
                bd_d = eneg_q ? CH_MINUS : CH_PLUS;
                st_d = S_TE1;
            end
            S_TE1: if (emit_c) begin
                bv_d = 1'b1;
                bd_d = CH_0 + {4'h0, 4'(emag_q / 7'd10)};
                st_d = S_TE0;
            end
            S_TE0: if (emit_c) begin
                bv_d = 1'b1;
                bd_d = CH_0 + {4'h0, 4'(emag_q % 7'd10)};
                st_d = S_COMMA;
            end
            S_COMMA: if (emit_c) begin
                // reached once per finished value; head is still queued
                f_pop = 1'b1;
                left_d = left_q - CNT_W'(1);
                if (left_q == CNT_W'(1)) st_d = S_TERM;
                else begin
                    bv_d = 1'b1;
                    bd_d = CH_COMMA;
                    st_d = S_TLOAD;
                end
            end
            S_TERM: if (emit_c) begin
                bv_d = 1'b1;
                bd_d = CH_LF;
                be_d = 1'b1;
                st_d = S_IDLE;
            end
            default: st_d = S_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= S_IDLE;
            fmt_bin_q <= 1'b0;
            left_q <= '0;
            len_q <= '0;
            bix_q <= '0;
            idx_q <= '0;
            nd_q <= '0;
            pt_at_q <= '0;
            mag_q <= '0;
            neg_q <= 1'b0;
            nr3_q <= 1'b0;
            pt_q <= 1'b0;
            eneg_q <= 1'b0;
            emag_q <= '0;
            bv_q <= 1'b0;
            bd_q <= '0;
            be_q <= 1'b0;
        end else begin
            st_q <= st_d;
            fmt_bin_q <= fmt_bin_d;
            left_q <= left_d;
            len_q <= len_d;
            bix_q <= bix_d;
            idx_q <= idx_d;
            nd_q <= nd_d;
            pt_at_q <= pt_at_d;
            mag_q <= mag_d;
            neg_q <= neg_d;
            nr3_q <= nr3_d;
            pt_q <= pt_d;
            eneg_q <= eneg_d;
            emag_q <= emag_d;
            bv_q <= bv_d;
            bd_q <= bd_d;
            be_q <= be_d;
        end
    end

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_hash_lead: assert property (st_q == S_HASH && emit_c |=> bv_q && bd_q == CH_HASH)
        else $error("block does not open with number sign");
    a_ndig_count: assert property (st_q == S_NDIG && emit_c
        |=> bd_q == CH_0 + {4'h0, num_dig(32'($past(len_q)))})
        else $error("digit count byte wrong");
    a_len_value: assert property (st_q == S_IDLE && f_valid |=> len_q == LEN_W'({left_q, 3'h0}))
        else $error("length is not eight bytes per value");
    a_end_newline: assert property (bv_q && be_q |-> bd_q == CH_LF)
        else $error("end flag without newline");
    a_msb_first: assert property (st_q == S_BIN && emit_c && f_valid && bix_q == LAST_BYTE_IX
        |=> bd_q == $past(h_top))
        else $error("first payload byte is not the top byte");
    a_bin_eight: assert property (f_pop && fmt_bin_q |-> st_q == S_BIN && bix_q == '0)
        else $error("value popped before eight bytes");
    a_comma_sep: assert property (f_pop && !fmt_bin_q && left_q > CNT_W'(1)
        |=> bd_q == CH_COMMA ##1 st_q == S_TSIGN || st_q == S_TLOAD)
        else $error("text values not comma separated");
    a_txt_sign: assert property (st_q == S_TSIGN && emit_c
        |=> bd_q == ($past(neg_q) ? CH_MINUS : CH_PLUS))
        else $error("sign character wrong");
    a_txt_digit: assert property (st_q == S_TDIG && emit_c |=> bd_q >= CH_0 && bd_q <= CH_9)
        else $error("digit character out of range");
    a_fmt_hold: assert property (st_q != S_IDLE |=> $stable(fmt_bin_q))
        else $error("format changed inside a response");

    c_bin_done: cover property (st_q == S_TERM && emit_c && fmt_bin_q);
    c_txt_exp: cover property (st_q == S_TE && emit_c);
    c_txt_point: cover property (st_q == S_TPT && emit_c && !nr3_q);
    c_txt_comma: cover property (st_q == S_COMMA && emit_c && left_q > CNT_W'(1));
endmodule : mrf_formatter

`default_nettype wire

// ### design/mrf_pkg.sv
// mrf_pkg: constants, FIFO word layout and states of the response formatter.
// assumes the SystemVerilog-2012 package import style.
package mrf_pkg;
    // -----------------------------------------------------------------
    // widths
    // -----------------------------------------------------------------
    localparam int VAL_W    = 64;
    localparam int MANT_W   = 32;
    localparam int EXP_W    = 8;
    localparam int CNT_W    = 8;
    localparam int LEN_W    = 11;
    localparam int BYTE_W   = 8;
    localparam int NDIG_MAX = 10;
    localparam int FIFO_D   = 8;
    // -----------------------------------------------------------------
    // fifo word layout {count, dexp, mant, bits}
    // -----------------------------------------------------------------
    localparam int BITS_LSB = 0;
    localparam int MANT_LSB = BITS_LSB + VAL_W;
    localparam int DEXP_LSB = MANT_LSB + MANT_W;
    localparam int CNT_LSB  = DEXP_LSB + EXP_W;
    localparam int FIFO_W   = CNT_LSB + CNT_W;
    // -----------------------------------------------------------------
    // characters and fixed values
    // -----------------------------------------------------------------
    localparam logic [7:0] CH_HASH  = 8'h23;
    localparam logic [7:0] CH_0     = 8'h30;
    localparam logic [7:0] CH_9     = 8'h39;
    localparam logic [7:0] CH_PLUS  = 8'h2B;
    localparam logic [7:0] CH_MINUS = 8'h2D;
    localparam logic [7:0] CH_DOT   = 8'h2E;
    localparam logic [7:0] CH_COMMA = 8'h2C;
    localparam logic [7:0] CH_E     = 8'h45;
    localparam logic [7:0] CH_LF    = 8'h0A;
    localparam logic [6:0] EXP_CLAMP    = 7'h63;
    localparam logic [2:0] LAST_BYTE_IX = 3'h7;
    localparam int         LEN_SHIFT    = 3;
    // -----------------------------------------------------------------
    // formatter states
    // -----------------------------------------------------------------
    typedef enum logic [3:0] {
        S_IDLE, S_HASH, S_NDIG, S_LEN, S_BIN, S_TLOAD, S_TSIGN, S_TDIG,
        S_TPT, S_TZ, S_TE, S_TES, S_TE1, S_TE0, S_COMMA, S_TERM
    } mrf_state_e;
endpackage : mrf_pkg

// ### tb/mrf_reader.sv
// mrf_reader: bus controller model that takes response bytes and logs them.
// assumes one clock shared with the formatter; pacing is set by the bench.
`timescale 1ns/1ns
`default_nettype none

module mrf_reader (
    // clock
    input  wire logic       clk_i,
    // response byte stream
    input  wire logic       byte_valid_i,
    output logic            byte_ready_o,
    input  wire logic [7:0] byte_data_i,
    input  wire logic       byte_end_i,
    // pacing
    input  wire logic       stall_i,
    input  wire logic       slow_i
);
    // each entry is {end flag, byte}
    logic [8:0] got_q[$];

    // slow pacing is ready on every other cycle, a stall takes none
    initial begin
        byte_ready_o = 1'b0;
        forever begin
            @(negedge clk_i);
            byte_ready_o <= !stall_i && !(slow_i && byte_ready_o);
        end
    end

    always @(posedge clk_i) begin
        if (byte_valid_i && byte_ready_o) begin
            got_q.push_back({byte_end_i, byte_data_i});
        end
    end
endmodule : mrf_reader

`default_nettype wire

// ### tb/test_mrf_formatter.sv
// test_mrf_formatter: self-checking bench for the response formatter.
// assumes the reader model logs every byte the formatter hands over.
`timescale 1ns/1ns
`default_nettype none

module test_mrf_formatter
    import mrf_pkg::*;
;
    logic              clk;
    logic              rst_n;
    logic              fmt_binary;
    logic              val_valid;
    logic              val_ready;
    logic [VAL_W-1:0]  val_bits;
    logic [MANT_W-1:0] val_mant;
    logic [EXP_W-1:0]  val_dexp;
    logic [CNT_W-1:0]  val_count;
    logic              byte_valid;
    logic              byte_ready;
    logic [7:0]        byte_data;
    logic              byte_end;
    logic              stall;
    logic              slow;
    logic              refused;
    logic [7:0]        exp_q[$];
    int                fails;
    int                tests_run;

    mrf_formatter uut (
        .clk_i        (clk),
        .rst_n_i      (rst_n),
        .fmt_binary_i (fmt_binary),
        .val_valid_i  (val_valid),
        .val_ready_o  (val_ready),
        .val_bits_i   (val_bits),
        .val_mant_i   (val_mant),
        .val_dexp_i   (val_dexp),
        .val_count_i  (val_count),
        .byte_valid_o (byte_valid),
        .byte_ready_i (byte_ready),
        .byte_data_o  (byte_data),
        .byte_end_o   (byte_end)
    );

    mrf_reader rd (
        .clk_i        (clk),
        .byte_valid_i (byte_valid),
        .byte_ready_o (byte_ready),
        .byte_data_i  (byte_data),
        .byte_end_i   (byte_end),
        .stall_i      (stall),
        .slow_i       (slow)
    );

    // -----------------------------------------------------------------
    // clock, reset and watchdog
    // -----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial begin
        #(5000 * 50);
        fails++;
        $display("[ERR] %0t watchdog expired", $time);
        finish_test();
    end

    // -----------------------------------------------------------------
    // helpers
    // -----------------------------------------------------------------
    task automatic check_eq(input logic [8:0] got, input logic [8:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check_eq

    // values are offered after the falling edge and held until taken
    task automatic push(input logic [63:0] bits, input logic [31:0] mant, input logic [7:0] dexp,
                        input logic [7:0] cnt);
        int n;
        @(negedge clk);
        val_valid = 1'b1;
        val_bits  = bits;
        val_mant  = mant;
        val_dexp  = dexp;
        val_count = cnt;
        n = 0;
        // ready is judged at the falling edge, where it is settled; the
        // take then happens at the next rising edge
        while (val_ready !== 1'b1 && n < 200) begin
            refused = 1'b1;
            n++;
            @(negedge clk);
        end
        if (n >= 200) check_eq(9'h000, 9'h001, "value never taken");
        @(posedge clk);
        @(negedge clk);
        val_valid = 1'b0;
    endtask : push

    task automatic add_str(input string s);
        foreach (s[i]) exp_q.push_back(s[i]);
    endtask : add_str

    task automatic add_hdr(input int n);
        string d;
        d = $sformatf("%0d", 8 * n);
        add_str("#");
        add_str($sformatf("%0d", d.len()));
        add_str(d);
    endtask : add_hdr

    task automatic add_dbl(input logic [63:0] v);
        for (int k = 0; k < 8; k++) exp_q.push_back(v[63-8*k -: 8]);
    endtask : add_dbl

    // end flag expected on the final byte only
    task automatic expect_stream(input string what);
        int n;
        n = 0;
        while (rd.got_q.size() < exp_q.size() && n < 1000) begin
            n++;
            @(negedge clk);
        end
        repeat (4) @(negedge clk);
        check_eq(9'(rd.got_q.size()), 9'(exp_q.size()), {what, " length"});
        foreach (exp_q[i]) begin
            if (i < rd.got_q.size()) check_eq(rd.got_q[i], {i == exp_q.size() - 1, exp_q[i]}, what);
        end
        rd.got_q.delete();
        exp_q.delete();
    endtask : expect_stream

    // -----------------------------------------------------------------
    // scenarios
    // -----------------------------------------------------------------
    task automatic t_bin_one();
        fmt_binary = 1'b1;
        push(64'h400921FB54442D18, 32'h00000000, 8'h00, 8'h01);
        add_hdr(1);
        add_dbl(64'h400921FB54442D18);
        add_str("\n");
        expect_stream("binary single");
    endtask : t_bin_one

    // negative subnormal then zero, reader pacing slowly
    task automatic t_bin_sub();
        slow = 1'b1;
        push(64'h800000000000F001, 32'h00000000, 8'h00, 8'h02);
        push(64'h0000000000000000, 32'h00000000, 8'h00, 8'h05);
        add_hdr(2);
        add_dbl(64'h800000000000F001);
        add_dbl(64'h0000000000000000);
        add_str("\n");
        expect_stream("binary subnormal");
        slow = 1'b0;
    endtask : t_bin_sub

    // switching back to text right after a block
    task automatic t_text();
        fmt_binary = 1'b0;
        push(64'h0000000000000000, 32'h000003E8, 8'h00, 8'h04);
        push(64'h0000000000000000, 32'hFFFFFFF4, 8'hFF, 8'h00);
        push(64'h0000000000000000, 32'h000003E8, 8'h03, 8'h00);
        push(64'h0000000000000000, 32'h00000005, 8'h03, 8'h00);
        add_str("+1000,-1.2,+1.000E+06,+5.0E+03\n");
        expect_stream("text list");
    endtask : t_text

    // reader stalls for 60 cycles, past the queue refusing, then drains it empty
    task automatic t_fill();
        fmt_binary = 1'b1;
        stall = 1'b1;
        refused = 1'b0;
        add_hdr(10);
        fork
            begin
                for (int i = 0; i < 10; i++) begin
                    push({8'h3F, 8'(i), 48'h00000000A5A5}, 32'h00000000, 8'h00, 8'h0A);
                    add_dbl({8'h3F, 8'(i), 48'h00000000A5A5});
                end
            end
            begin
                repeat (60) @(negedge clk);
                stall = 1'b0;
            end
        join
        add_str("\n");
        check_eq({8'h00, refused}, 9'h001, "queue never refused");
        expect_stream("binary full queue");
        check_eq({8'h00, val_ready}, 9'h001, "queue not drained");
    endtask : t_fill

    // -----------------------------------------------------------------
    // verdict
    // -----------------------------------------------------------------
    task automatic finish_test();
        $display("tests_run=%0d fails=%0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test

    initial begin
        fails      = 0;
        tests_run  = 0;
        rst_n      = 1'b0;
        fmt_binary = 1'b0;
        val_valid  = 1'b0;
        val_bits   = 64'h0000000000000000;
        val_mant   = 32'h00000000;
        val_dexp   = 8'h00;
        val_count  = 8'h00;
        stall      = 1'b0;
        slow       = 1'b0;
        refused    = 1'b0;
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        t_bin_one();
        t_bin_sub();
        t_text();
        t_fill();
        finish_test();
    end
endmodule : test_mrf_formatter

`default_nettype wire
